/* File: hdl/plc_logic_cell.sv */
// The register offsets and the APB register port were decided locally.
`timescale 1ns/100ps

// Functional notes
// [R1] Long chains hop to same-parity clusters
// [R2] Chain breaks at row midpoint, restarts after
// [R3] n chained cells give 4n input function
// [R4] Four modes: normal, arithmetic, updown, clearable
// [R5] Seven logic inputs plus three register controls; the code has six: inputs a to d, carry in and cascade in
// [R6] Synchronous clock enable, optionally from input a
// [R7] Normal LUT fourth input: carry or input c
// [R8] LUT combined with cascade in drives cascade out
// [R9] Packing: input d feeds register directly
// [R10] Packed register keeps controls, outputs split
// [R11] Arithmetic: sum LUT and carry LUT
// [R12] Updown counter: enable, direction, synchronous load
// [R13] Clearable counter: load mux ANDed with clear
// [R14] Emulated bus: contention low, floating high
// [R15] Clear and preset active low, idle high
// [R16] Control a asynchronously loads input c; the code loads it at the next pclk edge
// [R17] Six clear and preset control modes
// [R18] Clear mode: either control line clears
// [R19] Chip reset overrides all, clears registers
// [R20] Preset by loading one or inverted clear
// [R21] Clear and preset: a presets, b clears
// [R22] Load with clear: a loads, b clears
// [R23] Load with preset: inverted register, b presets
// [R24] Load only: a drives preset and clear
// [R25] Register holds when enable is low
module plc_logic_cell
(
    input  wire logic                                pclk,
    input  wire logic                                presetn,
    input  wire logic                                psel,
    input  wire logic                                penable,
    input  wire logic                                pwrite,
    input  wire logic [31:0]                         paddr,
    input  wire logic [31:0]                         pwdata,
    output logic      [31:0]                         prdata,
    output logic                                     pready,
    output logic                                     pslverr,
    input  wire logic                                cell_input_a,
    input  wire logic                                cell_input_b,
    input  wire logic                                cell_input_c,
    input  wire logic                                cell_input_d,
    input  wire logic                                carry_in,
    input  wire logic                                cascade_in,
    input  wire logic                                cluster_control_a_n,
    input  wire logic                                cluster_control_b_n,
    input  wire logic                                chip_reset_n,
    input  wire logic [plc_pkg::PLC_TRI_DRIVERS-1:0] tri_en,
    input  wire logic [plc_pkg::PLC_TRI_DRIVERS-1:0] tri_data,
    output logic                                     local_out,
    output logic                                     global_out,
    output logic                                     carry_out,
    output logic                                     cascade_out,
    output logic                                     tri_bus
);
    import plc_pkg::*;

    function automatic logic lut_pick(input logic [15:0] table_v, input logic [3:0] idx);
        lut_pick = table_v[idx];
    endfunction : lut_pick

    function automatic logic tri_resolve(input logic [PLC_TRI_DRIVERS-1:0] en,
                                         input logic [PLC_TRI_DRIVERS-1:0] dat);
        logic found;
        logic val;
        found = 1'b0;
        val   = 1'b1;
        for (int i = 0; i < PLC_TRI_DRIVERS; i++)
        begin
            if (en[i])
            begin
                val   = found ? 1'b0 : dat[i];
                found = 1'b1;
            end
        end
        tri_resolve = val;
    endfunction : tri_resolve

    // Registers
    logic [PLC_CFG_WIDTH-1:0] cfg_q;
    logic [15:0]              lut_q;
    logic [7:0]               pos_q;
    logic [31:0]              prdata_q;
    logic                     pready_q;
    logic                     pslverr_q;
    logic                     cell_q;
    logic                     cell_d;
    logic                     local_q;
    logic                     global_q;
    logic                     carry_q;
    logic                     casc_q;
    logic                     tri_q;

    // Bus decode
    wire  [7:0] addr_lo     = paddr[7:0];
    wire        hit_cfg     = (paddr[31:8] == 24'h00_0000) && (addr_lo == PLC_CFG_OFF);
    wire        hit_lut     = (paddr[31:8] == 24'h00_0000) && (addr_lo == PLC_LUT_OFF);
    wire        hit_pos     = (paddr[31:8] == 24'h00_0000) && (addr_lo == PLC_POS_OFF);
    wire        hit_stat    = (paddr[31:8] == 24'h00_0000) && (addr_lo == PLC_STAT_OFF);
    wire        hit_any     = hit_cfg || hit_lut || hit_pos || hit_stat;
    wire        setup_ph    = psel && !penable;
    wire        access_done = psel && penable && pready_q;
    wire        wr_en       = access_done && pwrite && hit_any;

    // Configuration fields
    plc_mode_t mode;
    plc_cp_t   cp_mode;
    assign mode    = plc_mode_t'(cfg_q[PLC_CFG_MODE_LO +: 2]);
    assign cp_mode = plc_cp_t'(cfg_q[PLC_CFG_CP_LO +: 3]);
    wire carry_sel = cfg_q[PLC_CFG_CARRYSEL];
    wire pack_en   = cfg_q[PLC_CFG_PACK];
    wire ce_from_a = cfg_q[PLC_CFG_CE_A];
    wire casc_or   = cfg_q[PLC_CFG_CASC_OR];
    wire loc_reg   = cfg_q[PLC_CFG_LOC_REG];
    wire glb_reg   = cfg_q[PLC_CFG_GLB_REG];

    // Cascade chain position inside the row
    wire [4:0] cluster  = pos_q[PLC_POS_CLU_LO +: 5];
    wire [2:0] slot     = pos_q[PLC_POS_SLOT_LO +: 3];
    wire       at_last  = (slot == PLC_LAST_SLOT);
    wire       at_first = (slot == 3'h0);
    // Same-parity hop: the next cluster of this chain is two further along
    wire [4:0] next_clu = at_last ? 5'(cluster + PLC_CLUSTER_HOP) : cluster; // [R1]
    // No successor across the memory block in the middle of the row
    wire chain_end   = at_last && (cluster == PLC_MID_LAST_CLU); // [R2]
    wire chain_start = at_first && ((cluster == PLC_MID_NEXT_CLU) || (cluster < PLC_CLUSTER_HOP)); // [R2]
    // A chain start ignores its cascade input by taking the identity value
    wire casc_ident = casc_or ? 1'b0 : 1'b1;
    wire casc_eff   = chain_start ? casc_ident : cascade_in;

    // Register output; load-with-preset stores the value inverted
    wire inv_reg  = (cp_mode == PLC_CP_LD_PRE); // [R20] [R23]
    wire cell_out = inv_reg ? ~cell_q : cell_q;

    // Normal mode: one 4-input table
    wire [3:0] idx_norm = {cell_input_d, carry_sel ? carry_in : cell_input_c,
                           cell_input_b, cell_input_a}; // [R7]
    wire lut_norm = lut_pick(lut_q, idx_norm);

    // Arithmetic: low half is the result table, high half the carry table
    wire [3:0] idx_sum   = {1'b0, carry_in, cell_input_b, cell_input_a};
    wire [3:0] idx_cry   = {1'b1, carry_in, cell_input_b, cell_input_a};
    wire       arith_sum = lut_pick(lut_q, idx_sum); // [R11]
    wire       arith_cry = lut_pick(lut_q, idx_cry); // [R11]

    // Counters: direction sits in the cascade-in position for up/down only
    wire       cnt_dir  = (mode == PLC_UPDOWN) ? cascade_in : 1'b0; // [R12]
    wire [3:0] idx_cnt  = {1'b0, cnt_dir, carry_in, cell_out};
    wire [3:0] idx_ccry = {1'b1, cnt_dir, carry_in, cell_out};
    wire       cnt_lut  = lut_pick(lut_q, idx_cnt); // [R12]
    wire       cnt_cry  = lut_pick(lut_q, idx_ccry); // [R12]
    // Input b enables counting, input d selects a load of input c
    wire cnt_next = cell_input_b ? cnt_lut : cell_out; // [R12]
    wire cnt_mux  = cell_input_d ? cell_input_c : cnt_next; // [R12]
    // Synchronous clear is active low on the cascade-in position
    wire clr_cnt  = cnt_mux & cascade_in; // [R13]

    // Per-mode LUT view, carry and register data
    logic lut_res;
    logic carry_d;
    logic data_d;
    always_comb
    begin
        lut_res = lut_norm;
        carry_d = 1'b0;
        data_d  = pack_en ? cell_input_d : lut_norm; // [R9]
        case (mode) // [R4] [R5]
            PLC_NORMAL:
            begin
                lut_res = lut_norm;
                carry_d = 1'b0;
                data_d  = pack_en ? cell_input_d : lut_norm; // [R9]
            end
            PLC_ARITH:
            begin
                lut_res = arith_sum;
                carry_d = arith_cry;
                data_d  = arith_sum;
            end
            PLC_UPDOWN:
            begin
                lut_res = cnt_lut;
                carry_d = cnt_cry;
                data_d  = cnt_mux;
            end
            PLC_CLRCNT:
            begin
                lut_res = cnt_lut;
                carry_d = cnt_cry;
                data_d  = clr_cnt; // [R13]
            end
            default:
            begin
                lut_res = lut_norm;
                carry_d = 1'b0;
                data_d  = lut_norm;
            end
        endcase
    end

    // Cascade is AND, or OR by inversion; counters use that input otherwise
    wire casc_use  = (mode == PLC_NORMAL) || (mode == PLC_ARITH);
    wire casc_comb = casc_or ? (lut_res | casc_eff) : (lut_res & casc_eff); // [R3] [R8]
    wire casc_d    = casc_use ? casc_comb : lut_res; // [R8] [R11]

    // Clear and preset generation, both active low onto the stored bit
    logic clr_n;
    logic pre_n;
    always_comb
    begin
        clr_n = 1'b1; // [R15]
        pre_n = 1'b1; // [R15]
        case (cp_mode) // [R17]
            PLC_CP_CLR:
            begin
                clr_n = cluster_control_a_n & cluster_control_b_n; // [R18]
                pre_n = 1'b1; // [R18]
            end
            PLC_CP_PRE:
            begin
                pre_n = cluster_control_a_n; // [R20]
            end
            PLC_CP_CLR_PRE:
            begin
                pre_n = cluster_control_a_n; // [R21]
                clr_n = cluster_control_b_n; // [R21]
            end
            PLC_CP_LD_CLR:
            begin
                pre_n = cluster_control_a_n | ~cell_input_c; // [R22]
                clr_n = (cluster_control_a_n | cell_input_c) & cluster_control_b_n; // [R22]
            end
            PLC_CP_LD_PRE:
            begin
                // Stored bit is inverted, so load drives the opposite path
                pre_n = cluster_control_a_n | cell_input_c; // [R23]
                clr_n = (cluster_control_a_n | ~cell_input_c) & cluster_control_b_n; // [R23]
            end
            PLC_CP_LD:
            begin
                pre_n = cluster_control_a_n | ~cell_input_c; // [R24] [R16]
                clr_n = cluster_control_a_n | cell_input_c; // [R24] [R16]
            end
            default:
            begin
                clr_n = 1'b1;
                pre_n = 1'b1;
            end
        endcase
    end

    wire ce        = ce_from_a ? cell_input_a : 1'b1; // [R6]
    wire store_d   = inv_reg ? ~data_d : data_d;
    wire async_idle = chip_reset_n && clr_n && pre_n;

    // Controls are sampled on pclk; they act regardless of clock enable
    always_comb
    begin
        if (!chip_reset_n)
            cell_d = 1'b0; // [R19]
        else if (!clr_n)
            cell_d = 1'b0;
        else if (!pre_n)
            cell_d = 1'b1;
        else if (ce)
            cell_d = store_d; // [R25] [R10]
        else
            cell_d = cell_q; // [R25]
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cell_q <= 1'b0;
        else
            cell_q <= cell_d;
    end

    // Two outputs select register or table independently
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            local_q  <= 1'b0;
            global_q <= 1'b0;
            carry_q  <= 1'b0;
            casc_q   <= 1'b0;
            tri_q    <= 1'b1;
        end
        else
        begin
            local_q  <= loc_reg ? cell_out : lut_res; // [R10]
            global_q <= glb_reg ? cell_out : lut_res; // [R10]
            carry_q  <= carry_d;
            casc_q   <= casc_d;
            tri_q    <= tri_resolve(tri_en, tri_data); // [R14]
        end
    end

    // Register writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_q <= PLC_CFG_RST[PLC_CFG_WIDTH-1:0];
            lut_q <= PLC_LUT_RST;
            pos_q <= PLC_POS_RST;
        end
        else if (wr_en)
        begin
            if (hit_cfg)
                cfg_q <= pwdata[PLC_CFG_WIDTH-1:0];
            else if (hit_lut)
                lut_q <= pwdata[15:0];
            else if (hit_pos)
                pos_q <= pwdata[7:0];
        end
    end

    // Read data and status
    logic [31:0] stat_v;
    logic [31:0] rd_v;
    always_comb
    begin
        stat_v = 32'h0000_0000;
        stat_v[PLC_ST_CELL]       = cell_out;
        stat_v[PLC_ST_LUT]        = lut_res;
        stat_v[PLC_ST_CARRY]      = carry_q;
        stat_v[PLC_ST_CASC]       = casc_q;
        stat_v[PLC_ST_TRI]        = tri_q;
        stat_v[PLC_ST_END]        = chain_end;
        stat_v[PLC_ST_NEXT +: 5]  = next_clu;
        if (hit_cfg)
            rd_v = {21'h00_0000, cfg_q};
        else if (hit_lut)
            rd_v = {16'h0000, lut_q};
        else if (hit_pos)
            rd_v = {24'h00_0000, pos_q};
        else if (hit_stat)
            rd_v = stat_v;
        else
            rd_v = 32'h0000_0000;
    end

    // No wait state: ready rises in the first access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
        else
        begin
            pready_q  <= setup_ph;
            pslverr_q <= setup_ph && !hit_any;
            prdata_q  <= (setup_ph && !pwrite) ? rd_v : 32'h0000_0000;
        end
    end

    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = pslverr_q;
    assign local_out   = local_q;
    assign global_out  = global_q;
    assign carry_out   = carry_q;
    assign cascade_out = casc_q;
    assign tri_bus     = tri_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chip_reset_a: assert property (!chip_reset_n |=> cell_q == 1'b0) // [R19]
        else $error("chip reset did not clear cell register");
    async_clear_a: assert property ((cp_mode == PLC_CP_CLR) && chip_reset_n &&
        (!cluster_control_a_n || !cluster_control_b_n) |=> !cell_out) // [R18]
        else $error("clear mode did not clear");
    async_load_a: assert property ((cp_mode == PLC_CP_LD) && chip_reset_n &&
        !cluster_control_a_n && $stable(cfg_q) |=> cell_out == $past(cell_input_c)) // [R16]
        else $error("load did not copy input c");
    hold_no_ce_a: assert property (async_idle && !ce && $stable(cfg_q) |=> $stable(cell_q)) // [R25]
        else $error("register changed without enable");
    tri_float_a: assert property (tri_en == '0 |=> tri_bus) // [R14]
        else $error("floating bus not high");
    tri_contend_a: assert property ($countones(tri_en) > 1 |=> !tri_bus) // [R14]
        else $error("contending bus not low");
    clr_pre_a: assert property ((cp_mode == PLC_CP_CLR_PRE) && chip_reset_n &&
        !cluster_control_a_n && cluster_control_b_n |=> cell_out) // [R21]
        else $error("control a did not preset");
    load_pre_a: assert property ((cp_mode == PLC_CP_LD_PRE) && chip_reset_n &&
        cluster_control_a_n && !cluster_control_b_n && $stable(cfg_q) |=> cell_out) // [R23]
        else $error("control b did not preset");
    sync_clear_a: assert property ((mode == PLC_CLRCNT) && async_idle && ce &&
        !cascade_in && $stable(cfg_q) |=> !cell_out) // [R13]
        else $error("synchronous clear failed");
    pack_path_a: assert property ((mode == PLC_NORMAL) && pack_en && async_idle && ce &&
        $stable(cfg_q) |=> cell_out == $past(cell_input_d)) // [R9]
        else $error("packed register missed input d");
    apb_ready_a: assert property (setup_ph |=> pready ##1 !pready)
        else $error("ready timing wrong");

endmodule : plc_logic_cell

/* File: shared/plc_pkg.sv */
package plc_pkg;

    // Register byte offsets
    localparam logic [7:0] PLC_CFG_OFF  = 8'h00;
    localparam logic [7:0] PLC_LUT_OFF  = 8'h04;
    localparam logic [7:0] PLC_POS_OFF  = 8'h08;
    localparam logic [7:0] PLC_STAT_OFF = 8'h0c;

    localparam logic [31:0] PLC_CFG_RST = 32'h0000_0000;
    localparam logic [15:0] PLC_LUT_RST = 16'h0000;
    localparam logic [7:0]  PLC_POS_RST = 8'h00;

    // Configuration fields
    localparam int PLC_CFG_MODE_LO  = 0;
    localparam int PLC_CFG_CP_LO    = 2;
    localparam int PLC_CFG_CARRYSEL = 5;
    localparam int PLC_CFG_PACK     = 6;
    localparam int PLC_CFG_CE_A     = 7;
    localparam int PLC_CFG_CASC_OR  = 8;
    localparam int PLC_CFG_LOC_REG  = 9;
    localparam int PLC_CFG_GLB_REG  = 10;
    localparam int PLC_CFG_WIDTH    = 11;

    // Position fields: cluster index and slot inside the cluster
    localparam int PLC_POS_CLU_LO  = 0;
    localparam int PLC_POS_SLOT_LO = 5;

    // Status fields
    localparam int PLC_ST_CELL  = 0;
    localparam int PLC_ST_LUT   = 1;
    localparam int PLC_ST_CARRY = 2;
    localparam int PLC_ST_CASC  = 3;
    localparam int PLC_ST_TRI   = 4;
    localparam int PLC_ST_END   = 5;
    localparam int PLC_ST_NEXT  = 6;

    // Row geometry for the cascade chain
    localparam logic [2:0] PLC_LAST_SLOT    = 3'h7;
    localparam logic [4:0] PLC_CLUSTER_HOP  = 5'h02;
    localparam logic [4:0] PLC_MID_LAST_CLU = 5'h11;
    localparam logic [4:0] PLC_MID_NEXT_CLU = 5'h12;
    localparam int         PLC_TRI_DRIVERS  = 4;

    typedef enum logic [1:0] {
        PLC_NORMAL,
        PLC_ARITH,
        PLC_UPDOWN,
        PLC_CLRCNT
    } plc_mode_t;

    typedef enum logic [2:0] {
        PLC_CP_CLR,
        PLC_CP_PRE,
        PLC_CP_CLR_PRE,
        PLC_CP_LD_CLR,
        PLC_CP_LD_PRE,
        PLC_CP_LD,
        PLC_CP_NONE_A,
        PLC_CP_NONE_B
    } plc_cp_t;

endpackage : plc_pkg

/* File: dv/plc_partner.sv */
`timescale 1ns/100ps

// Neighbouring cells and user logic: registered chain and bus-driver outputs
module plc_partner
    import plc_pkg::*;
(
    input  wire logic                                pclk,
    input  wire logic                                presetn,
    input  wire logic                                slow,
    input  wire logic [2*PLC_TRI_DRIVERS+1:0]        cmd,
    output logic                                     carry_in,
    output logic                                     cascade_in,
    output logic      [plc_pkg::PLC_TRI_DRIVERS-1:0] tri_en,
    output logic      [plc_pkg::PLC_TRI_DRIVERS-1:0] tri_data
);
    logic [2*PLC_TRI_DRIVERS+1:0] hold_q;

    // Slow answers add a stage, as a farther neighbour would
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hold_q <= '0;
            {carry_in, cascade_in, tri_en, tri_data} <= '0;
        end
        else
        begin
            hold_q <= cmd;
            {carry_in, cascade_in, tri_en, tri_data} <= slow ? hold_q : cmd;
        end
    end
endmodule : plc_partner

/* File: dv/tb_programmable_logic_cell.sv */
`timescale 1ns/100ps

module tb_programmable_logic_cell;
    import plc_pkg::*;
    typedef struct packed { logic [32:0] v; logic [32:0] m; } plc_exp_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata;
    logic        in_a, in_b, in_c, in_d, ctl_a_n, ctl_b_n, chip_reset_n;
    logic        carry_in, cascade_in, local_out, global_out, carry_out, cascade_out, tri_bus;
    logic [3:0]  tri_en, tri_data;
    logic [9:0]  cmd;
    logic        slow, chk_port;
    logic [15:0] seed, lut;
    logic [31:0] base;
    logic [32:0] got;
    plc_exp_t    e;
    plc_exp_t    exp_q[$];
    int          n_errors, samples_checked, cycles;

    plc_logic_cell plc_logic_cell_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cell_input_a(in_a),
        .cell_input_b(in_b), .cell_input_c(in_c), .cell_input_d(in_d),
        .carry_in(carry_in), .cascade_in(cascade_in), .cluster_control_a_n(ctl_a_n),
        .cluster_control_b_n(ctl_b_n), .chip_reset_n(chip_reset_n), .tri_en(tri_en),
        .tri_data(tri_data), .local_out(local_out), .global_out(global_out),
        .carry_out(carry_out), .cascade_out(cascade_out), .tri_bus(tri_bus));
    plc_partner plc_partner_i (.pclk(pclk), .presetn(presetn), .slow(slow), .cmd(cmd),
        .carry_in(carry_in), .cascade_in(cascade_in), .tri_en(tri_en),
        .tri_data(tri_data));

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    // Contention resolves low, an undriven bus reads high
    function automatic logic tri_exp(input logic [3:0] en, input logic [3:0] dt);
        case ($countones(en))
            0: return 1'b1;
            1: return |(en & dt);
            default: return 1'b0;
        endcase
    endfunction : tri_exp

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {24'h0, a};
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk iff pready === 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [32:0] v, input logic [32:0] m);
        exp_q.push_back('{v, m});
        apb(1'b0, a, 32'h0);
    endtask : rd

    task automatic st(input int k, input logic b);
        rd(PLC_STAT_OFF, 33'(b) << k, 33'h1 << k);
    endtask : st

    task automatic cfg(input logic [31:0] v);
        apb(1'b1, PLC_CFG_OFF, v);
    endtask : cfg

    task automatic cap(input logic v);
        in_d <= v;
        in_a <= 1'b1;
        tick(2);
        in_a <= 1'b0;
        tick(1);
    endtask : cap

    task automatic pulse(input int cp, input logic cv, an, bn, rn, ex);
        cfg(base | (cp << PLC_CFG_CP_LO));
        in_c         <= cv;
        ctl_a_n      <= an;
        ctl_b_n      <= bn;
        chip_reset_n <= rn;
        tick(2);
        {ctl_a_n, ctl_b_n, chip_reset_n} <= 3'b111;
        tick(2);
        st(PLC_ST_CELL, ex);
    endtask : pulse

    // Port sample order: tri_bus, cascade_out, carry_out, global_out, local_out
    task automatic pchk(input logic [4:0] v, input logic [4:0] m);
        exp_q.push_back('{{28'h0, v}, {28'h0, m}});
        tick(3);
        chk_port <= 1'b1;
        @(posedge pclk);
        chk_port <= 1'b0;
    endtask : pchk

    // Results arrive either as completed reads or as port samples
    always @(posedge pclk)
    begin
        if ((psel && penable && pready && !pwrite) || chk_port)
        begin
            got = chk_port ? {28'h0, tri_bus, cascade_out, carry_out, global_out, local_out}
                           : {pslverr, prdata};
            e = exp_q.pop_front();
            samples_checked++;
            if ((got & e.m) !== e.v)
            begin
                n_errors++;
                $display("MISMATCH t=%0t got %h exp %h", $time, got, e.v);
            end
        end
    end

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            tally_and_finish();
        end
    end

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {in_a, in_b, in_c, in_d, cmd, slow, chk_port} = '0;
        {ctl_a_n, ctl_b_n, chip_reset_n} = 3'b111;
        presetn = 1'b0;
        seed = 16'd35242;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(PLC_CFG_OFF, {1'b0, PLC_CFG_RST}, '1);
        rd(PLC_LUT_OFF, {17'h0, PLC_LUT_RST}, '1);
        rd(PLC_POS_OFF, {25'h0, PLC_POS_RST}, '1);
        rd(8'h1c, 33'h1_0000_0000, '1);
        $display("registers done");
        for (int i = 0; i < 16; i++)
        begin
            seed = lfsr(seed);
            slow <= seed[5];
            cmd  <= {2'b00, i[3:0], seed[3:0]};
            tick(4);
            st(PLC_ST_TRI, tri_exp(i[3:0], seed[3:0]));
            pchk({tri_exp(i[3:0], seed[3:0]), 4'h0}, 5'h10);
        end
        $display("bus emulation done");
        apb(1'b1, PLC_POS_OFF, 32'h62);
        seed = lfsr(seed);
        lut = seed;
        apb(1'b1, PLC_LUT_OFF, {16'h0, lut});
        for (int k = 0; k < 4; k++)
        begin
            cfg((k[0] << PLC_CFG_CARRYSEL) | (k[1] << PLC_CFG_CASC_OR));
            for (int i = 0; i < 16; i++)
            begin
                seed = lfsr(seed);
                cmd <= {i[2], seed[0], 8'h00};
                {in_d, in_b, in_a} <= {i[3], i[1], i[0]};
                in_c <= k[0] ? ~i[2] : i[2];
                tick(4);
                st(PLC_ST_LUT, lut[i]);
                st(PLC_ST_CASC, k[1] ? lut[i] | seed[0] : lut[i] & seed[0]);
            end
        end
        // Cascade input low, so only the chain-start identity can pass the table bit
        cmd <= 10'h000;
        apb(1'b1, PLC_POS_OFF, 32'h00);
        cfg(32'h0);
        tick(4);
        st(PLC_ST_CASC, lut[{1'b1, ~cmd[9], 2'b11} & 4'hb | {1'b0, in_c, 2'b00}]);
        apb(1'b1, PLC_POS_OFF, 32'he3);
        rd(PLC_STAT_OFF, 33'h5 << PLC_ST_NEXT, 33'h7e0);
        apb(1'b1, PLC_POS_OFF, 32'hf1);
        st(PLC_ST_END, 1'b1);
        $display("normal mode done");
        cfg(32'h1);
        apb(1'b1, PLC_LUT_OFF, 32'he896);
        {in_c, in_d} <= 2'b00;
        for (int i = 0; i < 8; i++)
        begin
            cmd <= {i[2], 1'b1, 8'h00};
            {in_b, in_a} <= i[1:0];
            tick(4);
            st(PLC_ST_LUT, ^i[2:0]);
            st(PLC_ST_CARRY, (i[0] & i[1]) | (i[2] & (i[0] | i[1])));
            pchk({1'b1, ^i[2:0], $countones(i[2:0]) > 1, 2'h0}, 5'h1c);
        end
        cfg(32'h2);
        apb(1'b1, PLC_LUT_OFF, 32'h0021);
        cmd <= 10'h000;
        {in_d, in_c, in_b} <= 3'b100;
        tick(3);
        st(PLC_ST_CELL, 1'b0);
        in_d <= 1'b0;
        in_b <= 1'b1;
        @(posedge pclk);
        in_b <= 1'b0;
        tick(3);
        st(PLC_ST_CELL, 1'b1);
        // Direction high: a count from one must use entry 5, not entry 1
        cmd <= 10'h100;
        tick(3);
        in_b <= 1'b1;
        tick(2);
        st(PLC_ST_CELL, 1'b1);
        cfg(32'h3);
        cmd <= 10'h100;
        {in_d, in_c} <= 2'b11;
        tick(3);
        st(PLC_ST_CELL, 1'b1);
        cmd <= 10'h000;
        tick(3);
        st(PLC_ST_CELL, 1'b0);
        $display("counter modes done");
        base = (32'h1 << PLC_CFG_PACK) | (32'h1 << PLC_CFG_CE_A);
        cfg(base);
        cap(1'b1);
        pulse(0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
        cap(1'b1);
        pulse(0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
        cap(1'b0);
        pulse(1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
        cap(1'b0);
        pulse(2, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
        pulse(2, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
        pulse(3, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
        pulse(3, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
        pulse(3, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        pulse(5, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
        pulse(5, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
        pulse(6, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        pulse(4, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
        pulse(4, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
        pulse(4, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
        pulse(4, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
        $display("clear and preset done");
        cfg(base);
        cap(1'b0);
        in_d <= 1'b1;
        tick(4);
        st(PLC_ST_CELL, 1'b0);
        cap(1'b1);
        st(PLC_ST_CELL, 1'b1);
        cap(1'b0);
        apb(1'b1, PLC_LUT_OFF, 32'hffff);
        cfg(base | (32'h1 << PLC_CFG_GLB_REG));
        pchk(5'h11, 5'h1f);
        cfg(base | (32'h1 << PLC_CFG_LOC_REG));
        pchk(5'h12, 5'h1f);
        $display("register packing done");
        tick(4);
        tally_and_finish();
    end
endmodule : tb_programmable_logic_cell
